// *** logic/ascp_consts.vh ***
`ifndef ASCP_CONSTS_VH
`define ASCP_CONSTS_VH
// character codes
`define ASCP_CH_START   8'h21
`define ASCP_CH_COMMA   8'h2C
`define ASCP_CH_CR      8'h0D
`define ASCP_CH_LF      8'h0A
`define ASCP_CH_0       8'h30
`define ASCP_CH_9       8'h39
`define ASCP_CH_UA      8'h41
`define ASCP_CH_UF      8'h46
`define ASCP_CH_LA      8'h61
`define ASCP_CH_LF_HEX  8'h66
`define ASCP_CH_SP      8'h20
`define ASCP_CH_TILDE   8'h7E
`define ASCP_CH_M       8'h4D
`define ASCP_CH_W       8'h57
// address values
`define ASCP_ADDR_RESET 8'h11
`define ASCP_ADDR_BCAST 8'h00
// memory location holding the bus address
`define ASCP_LOC_ADDR   16'h0076
// the location as it arrives: three decimal text digits
`define ASCP_LOC_TEXT   24'h313138
`define ASCP_LOC_LEN    4'h3
// reply header while held in reset: start plus the reset address
`define ASCP_HDR_RESET  24'h213131
// field sizes
`define ASCP_ARG_MAX    3'h4
`define ASCP_ARG_LEN    4'h8
`define ASCP_ARG_W      64
`endif

// *** logic/ascp_parser.v ***
`timescale 1ns/100ps
`include "ascp_consts.vh"
`default_nettype none

module ascp_parser (
	input  wire        sys_clk,
	input  wire        nrst,
	input  wire        bus_485,
	input  wire [7:0]  rx_data,
	input  wire        rx_valid,
	output reg  [15:0] cmd_token,
	output reg  [1:0]  cmd_len,
	output reg  [2:0]  arg_count,
	output reg  [63:0] arg0,
	output reg  [63:0] arg1,
	output reg  [63:0] arg2,
	output reg  [63:0] arg3,
	output reg         cmd_valid,
	output reg         cmd_bcast,
	output reg         frame_err,
	output reg  [7:0]  dev_addr,
	output reg  [23:0] reply_hdr
);

	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_AD1  = 6'h02;
	localparam [5:0] ST_AD2  = 6'h04;
	localparam [5:0] ST_ACOM = 6'h08;
	localparam [5:0] ST_CMD  = 6'h10;
	localparam [5:0] ST_ARG  = 6'h20;

	// hex digit test and value
	function is_hex;
		input [7:0] c;
		begin
			is_hex = (c >= `ASCP_CH_0 && c <= `ASCP_CH_9) ||
				(c >= `ASCP_CH_UA && c <= `ASCP_CH_UF) ||
				(c >= `ASCP_CH_LA && c <= `ASCP_CH_LF_HEX);
		end
	endfunction

	function [3:0] hex_val;
		input [7:0] c;
		begin
			if (c <= `ASCP_CH_9)
				hex_val = c[3:0];
			else
				hex_val = c[3:0] + 4'h9;
		end
	endfunction

	// nibble to upper case ASCII digit, for the reply header
	function [7:0] to_hex;
		input [3:0] n;
		begin
			if (n <= 4'h9)
				to_hex = `ASCP_CH_0 + {4'h0, n};
			else
				to_hex = `ASCP_CH_UA + {4'h0, n} - 8'h0A;
		end
	endfunction

	// argument holding hex text packs to a 16-bit value
	function [15:0] hex_field;
		input [63:0] a;
		input [3:0]  len;
		integer i;
		reg [15:0] v;
		begin
			v = 16'h0000;
			for (i = 0; i < 4; i = i + 1)
				if (i < len)
					v = {v[11:0], hex_val(a[63 - 8*i -: 8])};
			hex_field = v;
		end
	endfunction

	// reset release through two flops
	reg rst_s1_reg;
	reg rst_s2_reg;
	always @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	wire rst_n = rst_s2_reg;

	// mode pin from outside: two flop synchroniser
	reg mode_s1_reg;
	reg mode_s2_reg;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_s1_reg <= 1'b0;
			mode_s2_reg <= 1'b0;
		end else begin
			mode_s1_reg <= bus_485;
			mode_s2_reg <= mode_s1_reg;
		end
	end

	reg  [5:0]  state_reg;
	reg  [7:0]  addr_rx_reg;
	reg         bad_reg;
	reg  [1:0]  clen_reg;
	reg  [15:0] ctok_reg;
	reg  [2:0]  aidx_reg;
	reg  [3:0]  alen_reg;
	reg  [3:0]  alen0_reg;
	reg  [3:0]  alen1_reg;
	reg  [63:0] abuf_reg [0:3];
	wire [7:0]  ch = rx_data;
	wire        printable = (ch >= `ASCP_CH_SP) && (ch <= `ASCP_CH_TILDE);
	wire        take = rx_valid && (ch != `ASCP_CH_LF);

	// frame end decisions, evaluated on the CR byte
	wire        for_bcast = mode_s2_reg && (addr_rx_reg == `ASCP_ADDR_BCAST);
	wire        for_me = !mode_s2_reg || for_bcast ||
		(addr_rx_reg == dev_addr);
	wire        in_body = (state_reg == ST_CMD) || (state_reg == ST_ARG);
	wire        good_end = in_body && !bad_reg && (clen_reg != 2'h0);
	wire        is_mw = (clen_reg == 2'h2) &&
		(ctok_reg == {`ASCP_CH_M, `ASCP_CH_W});
	// memory write arguments come from the in-flight buffer
	wire [15:0] loc_val = hex_field(abuf_reg[0], alen0_reg);
	wire [15:0] new_val = hex_field(abuf_reg[1], alen1_reg);
	wire        loc_dec = (abuf_reg[0][63:40] == `ASCP_LOC_TEXT) &&
		(alen0_reg == `ASCP_LOC_LEN);
	wire        addr_ok = (alen1_reg != 4'h0) && (alen1_reg <= 4'h2) &&
		(new_val[7:0] != `ASCP_ADDR_BCAST);

	// the frame state machine
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= ST_IDLE;
			addr_rx_reg <= 8'h00;
			bad_reg     <= 1'b0;
			clen_reg    <= 2'h0;
			ctok_reg    <= 16'h0000;
			aidx_reg    <= 3'h0;
			alen_reg    <= 4'h0;
			alen0_reg   <= 4'h0;
			alen1_reg   <= 4'h0;
			abuf_reg[0] <= 64'h0;
			abuf_reg[1] <= 64'h0;
			abuf_reg[2] <= 64'h0;
			abuf_reg[3] <= 64'h0;
			cmd_token   <= 16'h0000;
			cmd_len     <= 2'h0;
			arg_count   <= 3'h0;
			arg0        <= 64'h0;
			arg1        <= 64'h0;
			arg2        <= 64'h0;
			arg3        <= 64'h0;
			cmd_valid   <= 1'b0;
			cmd_bcast   <= 1'b0;
			frame_err   <= 1'b0;
			dev_addr    <= `ASCP_ADDR_RESET;
			reply_hdr   <= `ASCP_HDR_RESET;
		end else begin
			cmd_valid <= 1'b0;
			frame_err <= 1'b0;
			reply_hdr <= {`ASCP_CH_START, to_hex(dev_addr[7:4]), to_hex(dev_addr[3:0])};
			if (take) begin
				if (ch == `ASCP_CH_CR) begin
					// end of frame: publish or drop, then rearm
					state_reg <= ST_IDLE;
					if (state_reg != ST_IDLE) begin
						if (good_end && for_me) begin
							cmd_valid <= 1'b1;
							cmd_bcast <= for_bcast;
							cmd_token <= ctok_reg;
							cmd_len   <= clen_reg;
							// an empty field after a trailing comma is not counted
							arg_count <= (state_reg == ST_ARG) ?
								aidx_reg + {2'h0, (alen_reg != 4'h0)} : 3'h0;
							arg0      <= abuf_reg[0];
							arg1      <= abuf_reg[1];
							arg2      <= abuf_reg[2];
							arg3      <= abuf_reg[3];
							if (mode_s2_reg && is_mw && state_reg == ST_ARG &&
								aidx_reg >= 3'h1 && loc_dec && addr_ok)
								dev_addr <= new_val[7:0];
						end else if (!good_end) begin
							frame_err <= 1'b1; // well-formed foreign frames stay silent
						end
					end
				end else if (!printable) begin
					bad_reg <= 1'b1;
				end else begin
					case (state_reg)
					ST_IDLE: begin
						bad_reg  <= 1'b0;
						clen_reg <= 2'h0;
						ctok_reg <= 16'h0000;
						aidx_reg <= 3'h0;
						alen_reg <= 4'h0;
						alen0_reg <= 4'h0;
						alen1_reg <= 4'h0;
						abuf_reg[0] <= 64'h0;
						abuf_reg[1] <= 64'h0;
						abuf_reg[2] <= 64'h0;
						abuf_reg[3] <= 64'h0;
						if (mode_s2_reg) begin
							// bytes before the start character are noise
							if (ch == `ASCP_CH_START)
								state_reg <= ST_AD1;
						end else begin
							state_reg <= ST_CMD;
							if (ch == `ASCP_CH_COMMA || ch == `ASCP_CH_START)
								bad_reg <= 1'b1;
							else begin
								ctok_reg <= {8'h00, ch};
								clen_reg <= 2'h1;
							end
						end
					end
					ST_AD1: begin
						if (!is_hex(ch))
							bad_reg <= 1'b1;
						addr_rx_reg <= {hex_val(ch), 4'h0};
						state_reg   <= ST_AD2;
					end
					ST_AD2: begin
						if (!is_hex(ch))
							bad_reg <= 1'b1;
						addr_rx_reg <= {addr_rx_reg[7:4], hex_val(ch)};
						state_reg   <= ST_ACOM;
					end
					ST_ACOM: begin
						if (ch != `ASCP_CH_COMMA)
							bad_reg <= 1'b1;
						state_reg <= ST_CMD;
					end
					ST_CMD: begin
						if (ch == `ASCP_CH_COMMA) begin
							state_reg <= ST_ARG;
							if (clen_reg == 2'h0)
								bad_reg <= 1'b1;
						end else if (clen_reg == 2'h2) begin
							bad_reg <= 1'b1; // token too long
						end else begin
							ctok_reg <= {ctok_reg[7:0], ch};
							clen_reg <= clen_reg + 2'h1;
						end
					end
					ST_ARG: begin
						if (ch == `ASCP_CH_COMMA) begin
							// trailing comma after the last argument is allowed
							if (aidx_reg == `ASCP_ARG_MAX - 3'h1) begin
								if (alen_reg != 4'h0)
									aidx_reg <= `ASCP_ARG_MAX;
							end else if (aidx_reg == `ASCP_ARG_MAX) begin
								bad_reg <= 1'b1;
							end else begin
								aidx_reg <= aidx_reg + 3'h1;
							end
							alen_reg <= 4'h0;
						end else if (aidx_reg == `ASCP_ARG_MAX) begin
							bad_reg <= 1'b1; // fifth argument
						end else if (alen_reg == `ASCP_ARG_LEN) begin
							bad_reg <= 1'b1; // argument too long to hold
						end else begin
							abuf_reg[aidx_reg[1:0]][63 - 8*alen_reg -: 8] <= ch;
							alen_reg <= alen_reg + 4'h1;
							if (aidx_reg == 3'h0)
								alen0_reg <= alen_reg + 4'h1;
							if (aidx_reg == 3'h1)
								alen1_reg <= alen_reg + 4'h1;
						end
					end
					default: state_reg <= ST_IDLE;
					endcase
				end
			end
		end
	end

endmodule // ascp_parser

`default_nettype wire

// *** testbench/ascp_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module ascp_host (
	input  wire logic       sys_clk,
	output var  logic [7:0] rx_data,
	output var  logic       rx_valid
);
	// idle line: no byte offered yet
	initial begin
		rx_data = 8'hFF;
		rx_valid = 1'b0;
	end
	// one byte a cycle; idle data flips so a stale byte never looks fresh
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(posedge sys_clk) #1;
			rx_valid = 1'b1;
			rx_data = s[i];
		end
		@(posedge sys_clk) #1;
		rx_valid = 1'b0;
		rx_data = ~rx_data;
	endtask
endmodule // ascp_host
`default_nettype wire

// *** testbench/ascp_chk_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module ascp_chk (
	input wire logic        sys_clk,
	input wire logic        nrst,
	input wire logic [7:0]  rx_data,
	input wire logic        rx_valid,
	input wire logic [15:0] cmd_token,
	input wire logic [1:0]  cmd_len,
	input wire logic [2:0]  arg_count,
	input wire logic        cmd_valid,
	input wire logic        cmd_bcast,
	input wire logic        frame_err,
	input wire logic [7:0]  dev_addr,
	input wire logic [23:0] reply_hdr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// results only follow a taken carriage return, and last one cycle
	cr_result_a: assert property ((cmd_valid || frame_err) |-> $past(rx_valid && rx_data == 8'h0D))
		else $error("result without carriage return");
	pulse_once_a: assert property ((cmd_valid || frame_err) |=> !cmd_valid && !frame_err)
		else $error("result strobe too long");
	one_result_a: assert property (!(cmd_valid && frame_err))
		else $error("valid and error together");
	// reply header tracks the address a cycle late
	hdr_start_a: assert property (reply_hdr[23:16] == 8'h21)
		else $error("reply header lacks start");
	hdr_follow_a: assert property ($stable(dev_addr) [*2] |-> $stable(reply_hdr))
		else $error("reply header moved alone");
	addr_cause_a: assert property ($changed(dev_addr) |-> cmd_valid)
		else $error("address moved without command");
	addr_nonzero_a: assert property (dev_addr != 8'h00)
		else $error("own address is broadcast");
	tok_len_a: assert property (cmd_valid |-> cmd_len == 2'h2 || (cmd_len == 2'h1 && cmd_token[15:8] == 8'h00))
		else $error("bad token length");
	arg_max_a: assert property (cmd_valid |-> arg_count <= 3'h4)
		else $error("too many arguments");
	bcast_cause_a: assert property ($changed(cmd_bcast) |-> cmd_valid)
		else $error("broadcast flag moved alone");
endmodule // ascp_chk
bind ascp_parser ascp_chk u_chk (.sys_clk, .nrst, .rx_data, .rx_valid, .cmd_token, .cmd_len,
	.arg_count, .cmd_valid, .cmd_bcast, .frame_err, .dev_addr, .reply_hdr);
`default_nettype wire

// *** testbench/tb_ascii_serial_command_parser.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_ascii_serial_command_parser;
	logic        sys_clk;
	logic        nrst;
	logic        bus_485;
	logic [7:0]  rx_data;
	logic        rx_valid;
	logic [15:0] cmd_token;
	logic [1:0]  cmd_len;
	logic [2:0]  arg_count;
	logic [63:0] arg0;
	logic [63:0] arg1;
	logic [63:0] arg2;
	logic [63:0] arg3;
	logic        cmd_valid;
	logic        cmd_bcast;
	logic        frame_err;
	logic [7:0]  dev_addr;
	logic [23:0] reply_hdr;
	int          bad_count;
	int          n_checks;
	int          cycles = 0;
	ascp_parser uut (.sys_clk, .nrst, .bus_485, .rx_data, .rx_valid, .cmd_token, .cmd_len,
		.arg_count, .arg0, .arg1, .arg2, .arg3, .cmd_valid, .cmd_bcast, .frame_err,
		.dev_addr, .reply_hdr);
	ascp_host host (.sys_clk, .rx_data, .rx_valid);
	// 40 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// strobes stand one cycle, so judge them right after the taking edge
	task automatic fr(input string s, input logic v, input logic e);
		host.send(s);
		chk("cmd_valid", cmd_valid, v);
		chk("frame_err", frame_err, e);
	endtask
	task automatic t_reset;
		chk("dev_addr", dev_addr, 8'h11);
		chk("reply_hdr", reply_hdr, 24'h213131);
		$display("reset test done");
	endtask
	task automatic t_addressed;
		fr("zz!11,F\nA,R\r", 1'b1, 1'b0);
		chk("cmd_token", cmd_token, 16'h4641);
		chk("cmd_len", cmd_len, 2'h2);
		chk("arg_count", arg_count, 3'h1);
		chk("arg0", arg0, {8'h52, 56'h0});
		chk("cmd_bcast", cmd_bcast, 1'b0);
		fr("!12,F\r", 1'b0, 1'b0);
		$display("addressed test done");
	endtask
	task automatic t_bcast;
		fr("!00,FV,1,2,3,4\r", 1'b1, 1'b0);
		chk("cmd_bcast", cmd_bcast, 1'b1);
		chk("arg_count", arg_count, 3'h4);
		chk("arg3", arg3, {8'h34, 56'h0});
		chk("arg1", arg1, {8'h32, 56'h0});
		chk("arg2", arg2, {8'h33, 56'h0});
		fr("!00,FV,1,2,3,4,\r", 1'b1, 1'b0);
		chk("arg_count", arg_count, 3'h4);
		$display("broadcast test done");
	endtask
	task automatic t_bad;
		fr("!1G,F\r", 1'b0, 1'b1);
		fr("!11,F,1,2,3,4,5\r", 1'b0, 1'b1);
		fr("!11,F\001\r", 1'b0, 1'b1);
		fr("!11,FAB\r", 1'b0, 1'b1);
		$display("malformed test done");
	endtask
	task automatic t_mw;
		fr("!00,MW,118,A5\r", 1'b1, 1'b0);
		chk("dev_addr", dev_addr, 8'hA5);
		@(posedge sys_clk) #1;
		chk("reply_hdr", reply_hdr, 24'h214135);
		fr("!11,F\r", 1'b0, 1'b0);
		fr("!a5,F\r", 1'b1, 1'b0);
		fr("!A5,MW,118,FF,\r", 1'b1, 1'b0);
		chk("arg_count", arg_count, 3'h2);
		chk("dev_addr", dev_addr, 8'hFF);
		fr("!FF,F\r", 1'b1, 1'b0);
		$display("address write test done");
	endtask
	// point-to-point mode: bare command, sync needs a few cycles
	task automatic t_232;
		bus_485 = 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
		fr("F\r", 1'b1, 1'b0);
		chk("cmd_token", cmd_token, 16'h0046);
		chk("cmd_len", cmd_len, 2'h1);
		$display("point-to-point test done");
	endtask
	// hang guard: the sequence needs well under 2000 cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			bad_count++;
			conclude;
		end
	end
	initial begin
		nrst = 1'b0;
		bus_485 = 1'b1;
		bad_count = 0;
		n_checks = 0;
		repeat (20) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		repeat (6) @(posedge sys_clk);
		#1;
		t_reset;
		t_addressed;
		t_bcast;
		t_bad;
		t_mw;
		t_232;
		conclude;
	end
endmodule // tb_ascii_serial_command_parser
`default_nettype wire
